// file: pviu_regs.vh
`ifndef PVIU_REGS_VH
`define PVIU_REGS_VH
// ram addresses of control nibbles
`define PVIU_ADDR_000 10'h000
`define PVIU_ADDR_001 10'h001
`define PVIU_ADDR_002 10'h002
`define PVIU_ADDR_003 10'h003
`define PVIU_ADDR_022 10'h022
`define PVIU_ADDR_023 10'h023
`define PVIU_ADDR_EDGE_SELECT_REG_1 10'h026
`define PVIU_ADDR_EDGE_SELECT_REG_2 10'h027
// bit positions within 000h/001h/002h/003h/022h/023h
`define PVIU_B_IE   0
`define PVIU_B_IF0  2
`define PVIU_B_IM0  3
`define PVIU_B_IF1  0
`define PVIU_B_IM1  1
`define PVIU_B_IFTA 2
`define PVIU_B_IMTA 3
`define PVIU_B_IFTB 0
`define PVIU_B_IMTB 1
`define PVIU_B_IFTC 2
`define PVIU_B_IMTC 3
`define PVIU_B_IFTD 0
`define PVIU_B_IMTD 1
`define PVIU_B_IF2  0
`define PVIU_B_IM2  1
`define PVIU_B_IF3  2
`define PVIU_B_IM3  3
`define PVIU_B_IFAD 0
`define PVIU_B_IMAD 1
`define PVIU_B_IFS  2
`define PVIU_B_IMS  3
// source index in flag vector
`define PVIU_S_EXT0 0
`define PVIU_S_EXT1 1
`define PVIU_S_TA   2
`define PVIU_S_TB   3
`define PVIU_S_EXT2 4
`define PVIU_S_TC   5
`define PVIU_S_EXT3 6
`define PVIU_S_TD   7
`define PVIU_S_AD   8
`define PVIU_S_SER  9
// vectors
`define PVIU_VEC_RESET 14'h0000
`define PVIU_VEC_1 14'h0002
`define PVIU_VEC_2 14'h0004
`define PVIU_VEC_3 14'h0006
`define PVIU_VEC_4 14'h0008
`define PVIU_VEC_5 14'h000a
`define PVIU_VEC_6 14'h000c
`define PVIU_VEC_7 14'h000e
`endif

// file: pviu_edge_det.v
`timescale 1ns/1ps
// edge detector with selectable edge: sel 00 none,01 fall,10 rise,11 both
module pviu_edge_det (
  // clock and reset
  input  wire       clock_i,
  input  wire       sys_rst_i,
  // pin and selection
  input  wire       pin_i,
  input  wire [1:0] sel_i,
  // detected edge
  output wire       hit_o
);
  reg prev;

  // previous pin level; idle level taken as high
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev <= 1'b1;
    end else begin
      prev <= pin_i;
    end
  end

  assign hit_o = (sel_i[0] & prev & ~pin_i) | (sel_i[1] & ~prev & pin_i);
endmodule // pviu_edge_det

// file: pviu_prio_enc.v
`timescale 1ns/1ps
`include "pviu_regs.vh"
// fixed priority encoder over seven vector groups, bit 0 highest
module pviu_prio_enc (
  // group requests
  input  wire [6:0]  grp_i,
  // result
  output reg         any_o,
  output reg  [13:0] vec_o
);
  always @* begin
    any_o = 1'b1;
    if (grp_i[0]) begin
      vec_o = `PVIU_VEC_1;
    end else if (grp_i[1]) begin
      vec_o = `PVIU_VEC_2;
    end else if (grp_i[2]) begin
      vec_o = `PVIU_VEC_3;
    end else if (grp_i[3]) begin
      vec_o = `PVIU_VEC_4;
    end else if (grp_i[4]) begin
      vec_o = `PVIU_VEC_5;
    end else if (grp_i[5]) begin
      vec_o = `PVIU_VEC_6;
    end else if (grp_i[6]) begin
      vec_o = `PVIU_VEC_7;
    end else begin
      any_o = 1'b0;
      vec_o = `PVIU_VEC_RESET;
    end
  end
endmodule // pviu_prio_enc

// file: pviu_irq_ctrl.v
`timescale 1ns/1ps
`include "pviu_regs.vh"
// interrupt control unit: flags, masks, enable, priority and ack sequence
module pviu_irq_ctrl (
  // clock and reset
  input  wire        clock_i,
  input  wire        sys_rst_i,
  // external pins
  input  wire        ext_irq_in_0_i,
  input  wire        ext_irq_in_1_i,
  input  wire        ext_irq_in_2_i,
  input  wire        ext_irq_in_3_i,
  input  wire        stop_cancel_input_i,
  // peripheral event pulses
  input  wire        timer_a_ovf_i,
  input  wire        timer_b_ovf_i,
  input  wire        timer_c_ovf_i,
  input  wire        timer_d_ovf_i,
  input  wire        serial_done_i,
  input  wire        adc_done_i,
  // cpu bit access to control ram
  input  wire [9:0]  ram_addr_i,
  input  wire        ram_wr_i,
  input  wire [3:0]  ram_wdata_i,
  // cpu core status
  input  wire        instr_end_i,
  input  wire        return_from_irq_instr_exec_i,
  input  wire        stop_mode_i,
  // data read back
  output reg  [3:0]  ram_rdata_o,
  // acknowledge sequence to cpu core
  output reg         irq_pending_o,
  output reg         push_o,
  output reg         vec_fetch_o,
  output reg  [13:0] vector_o,
  output reg         stop_wake_o,
  output reg         global_irq_enable_o
);
  // sequence states, one-hot
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_C1   = 4'b0010;
  localparam [3:0] ST_C2   = 4'b0100;
  localparam [3:0] ST_C3   = 4'b1000;

  reg  [9:0]  irq_flag;
  reg  [9:0]  irq_mask_bit;
  reg         global_irq_enable;
  reg  [3:0]  edge_select_reg_1;
  reg  [1:0]  edge_select_reg_2;
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [13:0] held_vec;
  reg  [9:0]  hw_set;
  reg  [9:0]  sw_clr;
  reg  [9:0]  next_mask;
  reg  [3:0]  next_rdata;
  wire [9:0]  active;
  wire [6:0]  grp;
  wire        any_req;
  wire [13:0] enc_vec;
  wire [3:0]  e_hit;
  wire        clr_ie;

  pviu_edge_det u_e0 (
    .clock_i (clock_i),
    .sys_rst_i (sys_rst_i),
    .pin_i (ext_irq_in_0_i),
    .sel_i (2'b01),
    .hit_o (e_hit[0])
  );
  pviu_edge_det u_e1 (
    .clock_i (clock_i),
    .sys_rst_i (sys_rst_i),
    .pin_i (ext_irq_in_1_i),
    .sel_i (2'b01),
    .hit_o (e_hit[1])
  );
  pviu_edge_det u_e2 (
    .clock_i (clock_i),
    .sys_rst_i (sys_rst_i),
    .pin_i (ext_irq_in_2_i),
    .sel_i (edge_select_reg_1[1:0]),
    .hit_o (e_hit[2])
  );
  pviu_edge_det u_e3 (
    .clock_i (clock_i),
    .sys_rst_i (sys_rst_i),
    .pin_i (ext_irq_in_3_i),
    .sel_i (edge_select_reg_1[3:2]),
    .hit_o (e_hit[3])
  );

  // hardware set terms per source
  always @* begin
    hw_set = 10'h000;
    hw_set[`PVIU_S_EXT0] = e_hit[0];
    hw_set[`PVIU_S_EXT1] = e_hit[1];
    hw_set[`PVIU_S_EXT2] = e_hit[2];
    hw_set[`PVIU_S_EXT3] = e_hit[3];
    hw_set[`PVIU_S_TA]   = timer_a_ovf_i;
    hw_set[`PVIU_S_TB]   = timer_b_ovf_i;
    hw_set[`PVIU_S_TC]   = timer_c_ovf_i;
    hw_set[`PVIU_S_TD]   = timer_d_ovf_i;
    hw_set[`PVIU_S_SER]  = serial_done_i;
    hw_set[`PVIU_S_AD]   = adc_done_i;
  end

  // decode of bit writes to control nibbles
  always @* begin
    sw_clr    = 10'h000;
    next_mask = irq_mask_bit;
    if (ram_wr_i) begin
      case (ram_addr_i)
        `PVIU_ADDR_000: begin
          sw_clr[`PVIU_S_EXT0] = ~ram_wdata_i[`PVIU_B_IF0];
          next_mask[`PVIU_S_EXT0] = ram_wdata_i[`PVIU_B_IM0];
        end
        `PVIU_ADDR_001: begin
          sw_clr[`PVIU_S_EXT1] = ~ram_wdata_i[`PVIU_B_IF1];
          next_mask[`PVIU_S_EXT1] = ram_wdata_i[`PVIU_B_IM1];
          sw_clr[`PVIU_S_TA] = ~ram_wdata_i[`PVIU_B_IFTA];
          next_mask[`PVIU_S_TA] = ram_wdata_i[`PVIU_B_IMTA];
        end
        `PVIU_ADDR_002: begin
          sw_clr[`PVIU_S_TB] = ~ram_wdata_i[`PVIU_B_IFTB];
          next_mask[`PVIU_S_TB] = ram_wdata_i[`PVIU_B_IMTB];
          sw_clr[`PVIU_S_TC] = ~ram_wdata_i[`PVIU_B_IFTC];
          next_mask[`PVIU_S_TC] = ram_wdata_i[`PVIU_B_IMTC];
        end
        `PVIU_ADDR_003: begin
          sw_clr[`PVIU_S_TD] = ~ram_wdata_i[`PVIU_B_IFTD];
          next_mask[`PVIU_S_TD] = ram_wdata_i[`PVIU_B_IMTD];
        end
        `PVIU_ADDR_022: begin
          sw_clr[`PVIU_S_EXT2] = ~ram_wdata_i[`PVIU_B_IF2];
          next_mask[`PVIU_S_EXT2] = ram_wdata_i[`PVIU_B_IM2];
          sw_clr[`PVIU_S_EXT3] = ~ram_wdata_i[`PVIU_B_IF3];
          next_mask[`PVIU_S_EXT3] = ram_wdata_i[`PVIU_B_IM3];
        end
        `PVIU_ADDR_023: begin
          sw_clr[`PVIU_S_AD] = ~ram_wdata_i[`PVIU_B_IFAD];
          next_mask[`PVIU_S_AD] = ram_wdata_i[`PVIU_B_IMAD];
          sw_clr[`PVIU_S_SER] = ~ram_wdata_i[`PVIU_B_IFS];
          next_mask[`PVIU_S_SER] = ram_wdata_i[`PVIU_B_IMS];
        end
        default: begin
          sw_clr = 10'h000;
        end
      endcase
    end
  end

  // flags, masks and edge selects
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_flag          <= 10'h000;
      irq_mask_bit      <= 10'h3ff;
      edge_select_reg_1 <= 4'h0;
      edge_select_reg_2 <= 2'h0;
    end else begin
      // writes only clear; hold until cleared, set wins
      irq_flag     <= (irq_flag & ~sw_clr) | hw_set;
      irq_mask_bit <= next_mask;
      if (ram_wr_i && ram_addr_i == `PVIU_ADDR_EDGE_SELECT_REG_1) begin
        edge_select_reg_1 <= ram_wdata_i;
      end
      if (ram_wr_i && ram_addr_i == `PVIU_ADDR_EDGE_SELECT_REG_2) begin
        edge_select_reg_2 <= ram_wdata_i[1:0];
      end
    end
  end

  // flag set and mask clear; mask 1 blocks
  assign active = irq_flag & ~irq_mask_bit;

  // shared groups OR their two terms
  assign grp = {active[`PVIU_S_AD]   | active[`PVIU_S_SER],
                active[`PVIU_S_TD],
                active[`PVIU_S_TC]   | active[`PVIU_S_EXT3],
                active[`PVIU_S_TB]   | active[`PVIU_S_EXT2],
                active[`PVIU_S_TA],
                active[`PVIU_S_EXT1],
                active[`PVIU_S_EXT0]};

  pviu_prio_enc u_enc (
    .grp_i (grp),
    .any_o (any_req),
    .vec_o (enc_vec)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (any_req && global_irq_enable) begin
          next_state = ST_C1;
        end
      end
      ST_C1: begin
        if (instr_end_i) begin
          next_state = ST_C2;
        end
      end
      ST_C2: begin
        next_state = ST_C3;
      end
      ST_C3: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // cleared in second cycle of service
  assign clr_ie = (next_state == ST_C2) && (state == ST_C1);

  // sequence, enable and vector registers
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state             <= ST_IDLE;
      global_irq_enable <= 1'b0;
      held_vec          <= `PVIU_VEC_RESET;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && next_state == ST_C1) begin
        held_vec <= enc_vec;
      end
      if (clr_ie) begin
        global_irq_enable <= 1'b0;
      end else if (return_from_irq_instr_exec_i) begin
        global_irq_enable <= 1'b1;
      end else if (ram_wr_i && ram_addr_i == `PVIU_ADDR_000) begin
        global_irq_enable <= ram_wdata_i[`PVIU_B_IE];
      end
    end
  end

  // read mux for control nibbles
  always @* begin
    case (ram_addr_i)
      `PVIU_ADDR_000: next_rdata = {irq_mask_bit[`PVIU_S_EXT0],
                                    irq_flag[`PVIU_S_EXT0], 1'b0,
                                    global_irq_enable};
      `PVIU_ADDR_001: next_rdata = {irq_mask_bit[`PVIU_S_TA],
                                    irq_flag[`PVIU_S_TA],
                                    irq_mask_bit[`PVIU_S_EXT1],
                                    irq_flag[`PVIU_S_EXT1]};
      `PVIU_ADDR_002: next_rdata = {irq_mask_bit[`PVIU_S_TC],
                                    irq_flag[`PVIU_S_TC],
                                    irq_mask_bit[`PVIU_S_TB],
                                    irq_flag[`PVIU_S_TB]};
      `PVIU_ADDR_003: next_rdata = {2'b00, irq_mask_bit[`PVIU_S_TD],
                                    irq_flag[`PVIU_S_TD]};
      `PVIU_ADDR_022: next_rdata = {irq_mask_bit[`PVIU_S_EXT3],
                                    irq_flag[`PVIU_S_EXT3],
                                    irq_mask_bit[`PVIU_S_EXT2],
                                    irq_flag[`PVIU_S_EXT2]};
      `PVIU_ADDR_023: next_rdata = {irq_mask_bit[`PVIU_S_SER],
                                    irq_flag[`PVIU_S_SER],
                                    irq_mask_bit[`PVIU_S_AD],
                                    irq_flag[`PVIU_S_AD]};
      default:        next_rdata = 4'h0;
    endcase
  end

  // registered outputs
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ram_rdata_o         <= 4'h0;
      irq_pending_o       <= 1'b0;
      push_o              <= 1'b0;
      vec_fetch_o         <= 1'b0;
      vector_o            <= `PVIU_VEC_RESET;
      stop_wake_o         <= 1'b0;
      global_irq_enable_o <= 1'b0;
    end else begin
      ram_rdata_o         <= next_rdata;
      irq_pending_o       <= (next_state == ST_C1);
      // push in cycles two and three
      push_o              <= (next_state == ST_C2) || (next_state == ST_C3);
      vec_fetch_o         <= (next_state == ST_C3);
      vector_o            <= (next_state == ST_C3) ? held_vec : vector_o;
      // stop cancel only in stop mode, vector 0000h
      stop_wake_o         <= stop_cancel_input_i & stop_mode_i;
      global_irq_enable_o <= clr_ie ? 1'b0 : (return_from_irq_instr_exec_i ? 1'b1 :
                             ((ram_wr_i && ram_addr_i == `PVIU_ADDR_000) ?
                              ram_wdata_i[`PVIU_B_IE] : global_irq_enable));
    end
  end
endmodule // pviu_irq_ctrl

// file: pviu_irq_ctrl_props.sv
`timescale 1ns/1ps
// timing checks on the ack sequence and readback
module pviu_irq_ctrl_props (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  // inputs watched
  input wire logic        stop_cancel_input_i,
  input wire logic        stop_mode_i,
  input wire logic        instr_end_i,
  input wire logic        return_from_irq_instr_exec_i,
  input wire logic [9:0]  ram_addr_i,
  // outputs watched
  input wire logic [3:0]  ram_rdata_o,
  input wire logic        irq_pending_o,
  input wire logic        push_o,
  input wire logic        vec_fetch_o,
  input wire logic [13:0] vector_o,
  input wire logic        stop_wake_o,
  input wire logic        global_irq_enable_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // wake only from stop mode
  property p_wake_off;
    stop_cancel_input_i && !stop_mode_i |=> !stop_wake_o;
  endproperty
  a_wake_off: assert property (p_wake_off)
    else $error("wake outside stop mode");
  property p_wake_on;
    stop_cancel_input_i && stop_mode_i |=> stop_wake_o;
  endproperty
  a_wake_on: assert property (p_wake_on)
    else $error("no wake in stop mode");
  // ack sequence shape
  property p_ack_end;
    irq_pending_o && instr_end_i |=>
      push_o && !irq_pending_o && !global_irq_enable_o;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("bad step after instruction end");
  property p_push2;
    $rose(push_o) |=> push_o ##1 !push_o;
  endproperty
  a_push2: assert property (p_push2)
    else $error("push not two cycles");
  property p_fetch;
    vec_fetch_o |-> push_o && $past(push_o);
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch not in third cycle");
  // vector values and hold
  // even slots hold a long jump
  property p_vec;
    vec_fetch_o |-> !vector_o[0] && vector_o >= 14'h0002
      && vector_o <= 14'h000e;
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector outside table");
  property p_hold;
    vec_fetch_o |=> vector_o == $past(vector_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("vector not held");
  // enable gating and unmapped readback
  property p_ack_en;
    $rose(irq_pending_o) |-> $past(global_irq_enable_o);
  endproperty
  a_ack_en: assert property (p_ack_en)
    else $error("ack while disabled");
  property p_ret;
    return_from_irq_instr_exec_i && !instr_end_i |=> global_irq_enable_o;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return did not enable");
  property p_unmap;
    ram_addr_i == 10'h010 |=> ram_rdata_o == 4'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  // main scenarios seen
  c_fetch: cover property (vec_fetch_o);
  c_wake: cover property (stop_wake_o);
  c_ret: cover property (return_from_irq_instr_exec_i);
endmodule // pviu_irq_ctrl_props

bind pviu_irq_ctrl pviu_irq_ctrl_props u_props (
  .clock_i             (clock_i),
  .sys_rst_i           (sys_rst_i),
  .stop_cancel_input_i (stop_cancel_input_i),
  .stop_mode_i         (stop_mode_i),
  .instr_end_i         (instr_end_i),
  .return_from_irq_instr_exec_i         (return_from_irq_instr_exec_i),
  .ram_addr_i          (ram_addr_i),
  .ram_rdata_o         (ram_rdata_o),
  .irq_pending_o       (irq_pending_o),
  .push_o              (push_o),
  .vec_fetch_o         (vec_fetch_o),
  .vector_o            (vector_o),
  .stop_wake_o         (stop_wake_o),
  .global_irq_enable_o (global_irq_enable_o)
);

// file: pviu_cpu_model.sv
`timescale 1ns/1ps
// cpu core stand-in: ends the current instruction after a delay
module pviu_cpu_model (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // ack handshake
  input  wire logic       irq_pending_i,
  input  wire logic [3:0] delay_i,
  output logic            instr_end_o
);
  logic [3:0] wait_cnt;
  // instruction end pulse, prompt or slow
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_cnt    <= 4'h0;
      instr_end_o <= 1'b0;
    end else begin
      instr_end_o <= 1'b0;
      wait_cnt    <= 4'h0;
      if (irq_pending_i && !instr_end_o) begin
        if (wait_cnt == delay_i) instr_end_o <= 1'b1;
        else wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // pviu_cpu_model

// file: prioritized_vectored_interrupt_unit_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the interrupt control unit
module prioritized_vectored_interrupt_unit_tb_top;
  // design signals
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  pins = 4'hf;
  logic [5:0]  evs = 6'h0;
  logic        stop_cancel_input_i = 1'b0;
  logic        stop_mode_i = 1'b0;
  logic        return_from_irq_instr_exec_i = 1'b0;
  logic        ram_wr_i = 1'b0;
  logic [9:0]  ram_addr_i = 10'h000;
  logic [3:0]  ram_wdata_i = 4'h0;
  logic [3:0]  cpu_delay = 4'h0;
  wire         ext_irq_in_0_i, ext_irq_in_1_i, ext_irq_in_2_i;
  wire         ext_irq_in_3_i, timer_a_ovf_i, timer_b_ovf_i;
  wire         timer_c_ovf_i, timer_d_ovf_i, serial_done_i, adc_done_i;
  wire         instr_end_i, irq_pending_o, push_o, vec_fetch_o;
  wire         stop_wake_o, global_irq_enable_o;
  wire [3:0]   ram_rdata_o;
  wire [13:0]  vector_o;
  int          err_total = 0;
  int          total_checks = 0;
  logic [9:0]  ctl [6] = '{10'h000, 10'h001, 10'h002, 10'h003,
                           10'h022, 10'h023};
  // pin and event fan-out
  assign {ext_irq_in_3_i, ext_irq_in_2_i} = pins[3:2];
  assign {ext_irq_in_1_i, ext_irq_in_0_i} = pins[1:0];
  assign {timer_a_ovf_i, timer_b_ovf_i, timer_c_ovf_i} = evs[5:3];
  assign {timer_d_ovf_i, serial_done_i, adc_done_i} = evs[2:0];
  always #5 clock_i = ~clock_i;
  pviu_irq_ctrl dut (
    .clock_i             (clock_i),
    .sys_rst_i           (sys_rst_i),
    .ext_irq_in_0_i      (ext_irq_in_0_i),
    .ext_irq_in_1_i      (ext_irq_in_1_i),
    .ext_irq_in_2_i      (ext_irq_in_2_i),
    .ext_irq_in_3_i      (ext_irq_in_3_i),
    .stop_cancel_input_i (stop_cancel_input_i),
    .timer_a_ovf_i       (timer_a_ovf_i),
    .timer_b_ovf_i       (timer_b_ovf_i),
    .timer_c_ovf_i       (timer_c_ovf_i),
    .timer_d_ovf_i       (timer_d_ovf_i),
    .serial_done_i       (serial_done_i),
    .adc_done_i          (adc_done_i),
    .ram_addr_i          (ram_addr_i),
    .ram_wr_i            (ram_wr_i),
    .ram_wdata_i         (ram_wdata_i),
    .instr_end_i         (instr_end_i),
    .return_from_irq_instr_exec_i         (return_from_irq_instr_exec_i),
    .stop_mode_i         (stop_mode_i),
    .ram_rdata_o         (ram_rdata_o),
    .irq_pending_o       (irq_pending_o),
    .push_o              (push_o),
    .vec_fetch_o         (vec_fetch_o),
    .vector_o            (vector_o),
    .stop_wake_o         (stop_wake_o),
    .global_irq_enable_o (global_irq_enable_o)
  );
  pviu_cpu_model u_cpu (
    .clock_i       (clock_i),
    .sys_rst_i     (sys_rst_i),
    .irq_pending_i (irq_pending_o),
    .delay_i       (cpu_delay),
    .instr_end_o   (instr_end_i)
  );
  // compare and count
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // control ram access
  task automatic wr(input logic [9:0] a, input logic [3:0] d);
    @(negedge clock_i);
    ram_addr_i = a;
    ram_wdata_i = d;
    ram_wr_i = 1'b1;
    @(negedge clock_i);
    ram_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [3:0] d);
    @(negedge clock_i);
    ram_addr_i = a;
    @(negedge clock_i);
    d = ram_rdata_o;
  endtask
  // bounded wait for the vector fetch
  task automatic fetch(input logic [13:0] v);
    int n;
    n = 0;
    while (vec_fetch_o !== 1'b1 && n < 40) begin
      @(negedge clock_i);
      n++;
    end
    chk({vec_fetch_o, push_o, vector_o[11:0]}, {2'b11, v[11:0]});
  endtask
  task automatic ret();
    @(negedge clock_i);
    return_from_irq_instr_exec_i = 1'b1;
    @(negedge clock_i);
    return_from_irq_instr_exec_i = 1'b0;
  endtask
  // reset state of control bits
  task automatic t_reset();
    logic [3:0] d;
    logic [3:0] mk [6] = '{4'hd, 4'hf, 4'hf, 4'h3, 4'hf, 4'hf};
    for (int i = 0; i < 6; i++) begin
      rd(ctl[i], d);
      chk({10'h0, d & mk[i]}, {10'h0, 4'ha & mk[i]});
    end
    chk({global_irq_enable_o, irq_pending_o, push_o}, 14'h0);
  endtask
  // writes cannot set flags, unmapped ignored
  task automatic t_sw();
    logic [3:0] d;
    wr(10'h001, 4'h5);
    rd(10'h001, d);
    chk({10'h0, d}, 14'h0);
    wr(10'h010, 4'hf);
    rd(10'h010, d);
    chk({10'h0, d}, 14'h0);
  endtask
  // all ten sources served in priority order
  task automatic t_prio();
    logic [3:0] d;
    logic [9:0] ca [10] = '{10'h000, 10'h001, 10'h001, 10'h002, 10'h022,
                            10'h002, 10'h022, 10'h003, 10'h023, 10'h023};
    logic [3:0] cd [10] = '{0, 4, 0, 4, 4, 0, 0, 0, 4, 0};
    logic [3:0] vc [10] = '{2, 4, 6, 8, 8, 10, 10, 12, 14, 14};
    wr(10'h026, 4'h5);
    for (int i = 0; i < 6; i++) wr(ctl[i], 4'h0);
    @(negedge clock_i);
    pins = 4'h0;
    @(negedge clock_i);
    pins = 4'hf;
    evs = 6'h3f;
    @(negedge clock_i);
    evs = 6'h0;
    wr(10'h000, 4'h5);
    for (int i = 0; i < 10; i++) begin
      fetch({10'h0, vc[i]});
      chk({13'h0, global_irq_enable_o}, 14'h0);
      if (i == 0) begin
        rd(10'h000, d);
        chk({10'h0, d & 4'hd}, 14'h4);
      end
      if (i == 3) begin
        rd(10'h022, d);
        chk({10'h0, d & 4'h5}, 14'h5);
      end
      wr(ca[i], cd[i]);
      ret();
    end
    repeat (20) @(negedge clock_i);
    chk({irq_pending_o, global_irq_enable_o}, 14'h1);
  endtask
  // mask and enable gating, slow core
  task automatic t_mask();
    logic [3:0] d;
    cpu_delay = 4'h3;
    wr(10'h001, 4'h8);
    evs = 6'h20;
    @(negedge clock_i);
    evs = 6'h0;
    repeat (10) @(negedge clock_i);
    chk({13'h0, irq_pending_o}, 14'h0);
    rd(10'h001, d);
    chk({10'h0, d}, 14'hc);
    wr(10'h000, 4'h4);
    wr(10'h001, 4'h4);
    repeat (10) @(negedge clock_i);
    chk({13'h0, irq_pending_o}, 14'h0);
    wr(10'h000, 4'h5);
    fetch(14'h0006);
    wr(10'h001, 4'h0);
    ret();
  endtask
  // rising and both-edge selects on ext 2/3
  task automatic t_edge();
    logic [3:0] d;
    wr(10'h000, 4'h0);
    wr(10'h026, 4'he);
    @(negedge clock_i);
    pins = 4'h3;
    rd(10'h022, d);
    chk({10'h0, d}, 14'h4);
    pins = 4'hf;
    rd(10'h022, d);
    chk({10'h0, d}, 14'h5);
    wr(10'h022, 4'h0);
    rd(10'h022, d);
    chk({10'h0, d}, 14'h0);
  endtask
  // stop cancel honoured only in stop mode
  task automatic t_stop();
    @(negedge clock_i);
    stop_cancel_input_i = 1'b1;
    @(negedge clock_i);
    chk({13'h0, stop_wake_o}, 14'h0);
    stop_mode_i = 1'b1;
    @(negedge clock_i);
    chk({13'h0, stop_wake_o}, 14'h1);
    stop_cancel_input_i = 1'b0;
    stop_mode_i = 1'b0;
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(negedge clock_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_sw();
    t_prio();
    t_mask();
    t_edge();
    t_stop();
    report_and_stop();
  end
  // watchdog
  initial begin
    #50000;
    err_total++;
    report_and_stop();
  end
endmodule // prioritized_vectored_interrupt_unit_tb_top
